// ==== rtl/fsr56_battery_timer.sv ====
`timescale 1ns/1ps
module fsr56_battery_timer
  import fsr56_pkg::*;
#(
  parameter int SHORT_CYC = LOAD_SHORT_CYC,
  parameter int LONG_CYC  = LOAD_LONG_CYC
) (
  input  wire logic ref_clk,
  input  wire logic reset,
  input  wire logic start,
  input  wire logic abort,
  input  wire logic long_sel,
  output logic      done
);

  logic [15:0] remaining;
  logic        running;

  always_ff @(posedge ref_clk) begin
    if (reset || abort) begin
      remaining <= 16'h0000;
      running   <= 1'b0;
      done      <= 1'b0;
    end else if (start) begin
      remaining <= long_sel ? 16'(LONG_CYC - 1) : 16'(SHORT_CYC - 1);
      running   <= 1'b1;
      done      <= 1'b0;
    end else if (running && remaining == 16'h0000) begin
      running <= 1'b0;
      done    <= 1'b1;
    end else begin
      remaining <= running ? remaining - 16'h0001 : remaining;
      done      <= 1'b0;
    end
  end

endmodule

// ==== rtl/fsr56_pkg.sv ====
package fsr56_pkg;

  // lock_dummy_suspend_config field positions
  localparam int FREEZE_POS   = 7;
  localparam int DUMMY_LSB    = 4;
  localparam int ERASE_POS    = 3;
  localparam int PROG_POS     = 2;
  localparam int ABORT_POS    = 1;
  localparam int ALIGN_POS    = 0;
  // battery_test_control field positions
  localparam int RESULT_LSB   = 6;
  localparam int THRESH_LSB   = 3;
  localparam int LOAD_LSB     = 1;
  localparam int LTIME_POS    = 0;

  localparam logic [7:0] CFG_RESET  = 8'h00;
  localparam logic [7:0] BAT_RESET  = 8'h00;
  localparam logic [7:0] CFG_WMASK  = 8'h73;
  localparam logic [7:0] BAT_WMASK  = 8'h3f;

  // command codes
  localparam logic [7:0] CMD_LOCK   = 8'h6f;
  localparam logic [7:0] LOCK_KEY1  = 8'h4d;
  localparam logic [7:0] LOCK_KEY2  = 8'h67;
  localparam logic [7:0] CMD_ALIGNQ = 8'heb;
  localparam logic [7:0] CMD_BATST  = 8'hef;
  localparam logic [7:0] CMD_ABORT  = 8'hf0;

  // battery result codes
  localparam logic [1:0] BAT_IDLE   = 2'h0;
  localparam logic [1:0] BAT_BUSY   = 2'h1;
  localparam logic [1:0] BAT_ABOVE  = 2'h2;
  localparam logic [1:0] BAT_BELOW  = 2'h3;

  localparam logic [2:0] DUMMY_MAX  = 3'h4;

  // load times at a 50 ns clock
  localparam int CLK_NS       = 50;
  localparam int LOAD_SHORT_NS = 100000;
  localparam int LOAD_LONG_NS  = 1000000;
  localparam int LOAD_SHORT_CYC = (LOAD_SHORT_NS + CLK_NS - 1) / CLK_NS;
  localparam int LOAD_LONG_CYC  = (LOAD_LONG_NS + CLK_NS - 1) / CLK_NS;

  typedef struct packed {
    logic       valid;
    logic [7:0] data;
    logic       first;
  } fsr56_byte_t;

  typedef struct packed {
    logic        valid;
    logic [23:0] addr;
    logic [7:0]  cmd;
  } fsr56_addr_t;

endpackage

// ==== rtl/fsr56_regs.sv ====
`timescale 1ns/1ps
module fsr56_regs
  import fsr56_pkg::*;
#(
  parameter int SHORT_CYC = LOAD_SHORT_CYC,
  parameter int LONG_CYC  = LOAD_LONG_CYC
) (
  input  wire logic        ref_clk,
  input  wire logic        reset,
  input  wire fsr56_byte_t cmd_byte,
  input  wire logic        wr_cfg,
  input  wire logic        wr_bat,
  input  wire logic [7:0]  wr_data,
  input  wire logic        erase_suspended,
  input  wire logic        prog_suspended,
  input  wire logic        battery_below,
  input  wire logic        battery_clear,
  input  wire fsr56_addr_t read_req,
  output logic [7:0]       lock_dummy_suspend_config,
  output logic [7:0]       battery_test_control,
  output logic [7:0]       battery_status_byte,
  output logic             battery_status_valid,
  output logic [3:0]       dummy_clocks,
  output logic [3:0]       dummy_extra_clocks,
  output logic             abort_accepted,
  output logic [1:0]       battery_load_drive,
  output logic [2:0]       battery_threshold_drive,
  output logic             battery_load_on,
  output fsr56_addr_t      read_fwd
);

  typedef enum logic [1:0] {LK_IDLE, LK_KEY1, LK_KEY2} fsr56_lock_t;

  fsr56_lock_t lock_state;
  logic        register_freeze_flag;
  logic [2:0]  dummy_cycle_count;
  logic        abort_cmd_allow;
  logic        quad_word_align;
  logic [1:0]  battery_result;
  logic [2:0]  battery_threshold_sel;
  logic [1:0]  battery_load_sel;
  logic        battery_load_time;
  logic        abort_cmd;
  logic        batst_cmd;
  logic        timer_done;

  function automatic logic [3:0] dummy_count(input logic [2:0] code);
    // mode-bit clocks are part of the total, never added
    dummy_count = (code > DUMMY_MAX) ? 4'h0 : {code + 3'h1, 1'b0};
  endfunction

  function automatic logic is_cmd(input fsr56_byte_t b, input logic [7:0] code);
    is_cmd = b.valid && b.first && b.data == code;
  endfunction

  assign abort_cmd = is_cmd(cmd_byte, CMD_ABORT) && abort_cmd_allow;
  assign batst_cmd = is_cmd(cmd_byte, CMD_BATST);

  ////////////////////////////////////////////////////////////////////////////
  // lock sequence

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      lock_state <= LK_IDLE;
    end else if (cmd_byte.valid) begin
      unique case (lock_state)
        LK_IDLE: lock_state <= is_cmd(cmd_byte, CMD_LOCK) ? LK_KEY1 : LK_IDLE;
        LK_KEY1: lock_state <= (!cmd_byte.first && cmd_byte.data == LOCK_KEY1) ? LK_KEY2 : LK_IDLE;
        LK_KEY2: lock_state <= LK_IDLE;
        default: lock_state <= LK_IDLE;
      endcase
    end
  end

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      register_freeze_flag <= CFG_RESET[FREEZE_POS];
    end else if (lock_state == LK_KEY2 && cmd_byte.valid && !cmd_byte.first
                 && cmd_byte.data == LOCK_KEY2) begin
      register_freeze_flag <= 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // writable fields

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      dummy_cycle_count <= CFG_RESET[DUMMY_LSB +: 3];
      abort_cmd_allow   <= CFG_RESET[ABORT_POS];
      quad_word_align   <= CFG_RESET[ALIGN_POS];
    end else if (wr_cfg) begin
      // read-only bits are never loaded from wr_data; the mask covers the dummy field only
      dummy_cycle_count <= wr_data[DUMMY_LSB +: 3] & CFG_WMASK[DUMMY_LSB +: 3];
      abort_cmd_allow   <= wr_data[ABORT_POS];
      quad_word_align   <= wr_data[ALIGN_POS];
    end
  end

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      battery_threshold_sel <= BAT_RESET[THRESH_LSB +: 3];
      battery_load_sel      <= BAT_RESET[LOAD_LSB +: 2];
      battery_load_time     <= BAT_RESET[LTIME_POS];
    end else if (wr_bat) begin
      battery_threshold_sel <= wr_data[THRESH_LSB +: 3] & BAT_WMASK[THRESH_LSB +: 3];
      battery_load_sel      <= wr_data[LOAD_LSB +: 2];
      battery_load_time     <= wr_data[LTIME_POS];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // battery test

  fsr56_battery_timer #(
    .SHORT_CYC (SHORT_CYC),
    .LONG_CYC  (LONG_CYC)
  ) u_timer (
    .ref_clk  (ref_clk),
    .reset    (reset),
    .start    (batst_cmd && battery_result != BAT_BUSY),
    .abort    (abort_cmd || battery_clear),
    .long_sel (battery_load_time),
    .done     (timer_done)
  );

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      battery_result <= BAT_IDLE;
    end else if (abort_cmd || battery_clear) begin
      battery_result <= BAT_IDLE;
    end else if (timer_done) begin
      battery_result <= battery_below ? BAT_BELOW : BAT_ABOVE;
    end else if (batst_cmd && battery_result != BAT_BUSY) begin
      battery_result <= BAT_BUSY;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      battery_status_byte  <= BAT_RESET;
      battery_status_valid <= 1'b0;
    end else begin
      battery_status_byte  <= battery_test_control;
      battery_status_valid <= batst_cmd;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // register images and drives

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      lock_dummy_suspend_config <= CFG_RESET;
      battery_test_control      <= BAT_RESET;
    end else begin
      lock_dummy_suspend_config <= {register_freeze_flag, dummy_cycle_count,
                                    erase_suspended,
                                    prog_suspended,
                                    abort_cmd_allow, quad_word_align};
      battery_test_control      <= {battery_result, battery_threshold_sel,
                                    battery_load_sel, battery_load_time};
    end
  end

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      dummy_clocks            <= 4'h0;
      dummy_extra_clocks      <= 4'h0;
      abort_accepted          <= 1'b0;
      battery_load_drive      <= 2'h0;
      battery_threshold_drive <= 3'h0;
      battery_load_on         <= 1'b0;
    end else begin
      dummy_clocks            <= dummy_count(dummy_cycle_count);
      dummy_extra_clocks      <= dummy_count(dummy_cycle_count) - 4'h2;
      abort_accepted          <= abort_cmd;
      battery_load_drive      <= battery_load_sel;
      battery_threshold_drive <= battery_threshold_sel;
      battery_load_on         <= battery_result == BAT_BUSY;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      read_fwd <= '0;
    end else begin
      read_fwd <= read_req;
      if (read_req.cmd == CMD_ALIGNQ && quad_word_align) begin
        read_fwd.addr[1:0] <= 2'b00;
      end
    end
  end

endmodule

// ==== tb/fsr56_host_model.sv ====
`timescale 1ns/1ps
module fsr56_host_model
  import fsr56_pkg::*;
(
  input  wire logic       ref_clk,
  input  wire logic       go,
  input  wire logic [7:0] data,
  input  wire logic       first,
  output fsr56_byte_t     cmd_byte
);
  // one byte per request, valid for one cycle; data is scrambled when idle
  always_ff @(posedge ref_clk) begin
    cmd_byte <= '{valid: go, data: go ? data : ~cmd_byte.data, first: go & first};
  end
endmodule

// ==== tb/fsr56_regs_monitor.sv ====
`timescale 1ns/1ps
module fsr56_regs_monitor
  import fsr56_pkg::*;
#(
  parameter int SHORT_CYC = LOAD_SHORT_CYC,
  parameter int LONG_CYC  = LOAD_LONG_CYC
) (
  input wire logic        ref_clk,
  input wire logic        reset,
  input wire fsr56_byte_t cmd_byte,
  input wire logic        erase_suspended,
  input wire logic        prog_suspended,
  input wire fsr56_addr_t read_req,
  input wire logic [7:0]  lock_dummy_suspend_config,
  input wire logic [7:0]  battery_test_control,
  input wire logic        battery_status_valid,
  input wire logic [3:0]  dummy_clocks,
  input wire logic        abort_accepted,
  input wire logic        battery_load_on,
  input wire fsr56_addr_t read_fwd
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (reset);
  wire  [7:0] cfg = lock_dummy_suspend_config;
  wire  [7:0] bat = battery_test_control;
  wire        is_abort = cmd_byte.valid & cmd_byte.first & (cmd_byte.data == CMD_ABORT);
  logic [1:0] up;
  // settles two edges after reset release
  always_ff @(posedge ref_clk) begin
    up <= reset ? 2'h0 : {up[0], 1'b1};
  end
  sequence s_stat;
    cmd_byte.valid && cmd_byte.first && cmd_byte.data == CMD_BATST && !battery_load_on;
  endsequence
  sequence s_report;
    battery_status_valid ##1 (bat[7:6] == BAT_BUSY);
  endsequence
  a_freeze_sticky: assert property (cfg[FREEZE_POS] |=> cfg[FREEZE_POS])
    else $error("freeze flag dropped");
  a_erase_flag: assert property (&up |-> cfg[ERASE_POS] == $past(erase_suspended))
    else $error("erase flag wrong");
  a_prog_flag: assert property (&up |-> cfg[PROG_POS] == $past(prog_suspended))
    else $error("program flag wrong");
  a_status_walk: assert property (s_stat |=> s_report)
    else $error("status report wrong");
  a_abort_gate: assert property (abort_accepted |-> $past(is_abort) && cfg[ABORT_POS])
    else $error("abort accepted wrongly");
  a_abort_clear: assert property (abort_accepted |=> bat[7:6] == BAT_IDLE)
    else $error("result not cleared");
  a_align_quad: assert property (read_req.valid && read_req.cmd == CMD_ALIGNQ && cfg[ALIGN_POS]
    |=> read_fwd.valid && read_fwd.addr[1:0] == 2'b00) else $error("address not aligned");
  a_align_other: assert property (read_req.valid && read_req.cmd != CMD_ALIGNQ
    |=> read_fwd.addr == $past(read_req.addr)) else $error("address altered");
  a_dummy_map: assert property (&up && cfg[6:4] <= DUMMY_MAX && $stable(cfg[6:4])
    |-> dummy_clocks == {cfg[6:4], 1'b0} + 4'h2) else $error("dummy count wrong");
endmodule

bind fsr56_regs fsr56_regs_monitor #(.SHORT_CYC(SHORT_CYC), .LONG_CYC(LONG_CYC)) fsr56_regs_monitor_i (
  .ref_clk(ref_clk), .reset(reset), .cmd_byte(cmd_byte), .erase_suspended(erase_suspended),
  .prog_suspended(prog_suspended), .read_req(read_req), .lock_dummy_suspend_config(lock_dummy_suspend_config),
  .battery_test_control(battery_test_control), .battery_status_valid(battery_status_valid),
  .dummy_clocks(dummy_clocks), .abort_accepted(abort_accepted), .battery_load_on(battery_load_on),
  .read_fwd(read_fwd));

// ==== tb/testbench.sv ====
`timescale 1ns/1ps
module testbench;
  import fsr56_pkg::*;
  localparam int SC = 4;
  localparam int LC = 8;
  logic ref_clk = 0, reset = 1, go = 0, first = 0, wr_cfg = 0, wr_bat = 0, battery_clear = 0;
  logic erase_suspended = 0, prog_suspended = 0, battery_below = 0, bsv, acc, lon;
  logic [7:0] data = 0, wr_data = 0, cfg, bat, bsb;
  logic [3:0] dck, dxk;
  logic [1:0] ldr;
  logic [2:0] tdr;
  fsr56_addr_t read_req = '0, read_fwd;
  fsr56_byte_t cmd_byte;
  int fail_count = 0, n_checks = 0, i, n;
  always #25 ref_clk = ~ref_clk;
  fsr56_host_model fsr56_host_model_i (.ref_clk(ref_clk), .go(go), .data(data), .first(first), .cmd_byte(cmd_byte));
  fsr56_regs #(.SHORT_CYC(SC), .LONG_CYC(LC)) fsr56_regs_i (.ref_clk(ref_clk), .reset(reset),
    .cmd_byte(cmd_byte), .wr_cfg(wr_cfg), .wr_bat(wr_bat), .wr_data(wr_data), .erase_suspended(erase_suspended),
    .prog_suspended(prog_suspended), .battery_below(battery_below), .battery_clear(battery_clear),
    .read_req(read_req), .lock_dummy_suspend_config(cfg), .battery_test_control(bat), .battery_status_byte(bsb),
    .battery_status_valid(bsv), .dummy_clocks(dck), .dummy_extra_clocks(dxk), .abort_accepted(acc),
    .battery_load_drive(ldr), .battery_threshold_drive(tdr), .battery_load_on(lon), .read_fwd(read_fwd));
  ////////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    n_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("unexpected at %0t: got %h want %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic c, input logic [7:0] d);
    @(posedge ref_clk) {wr_cfg, wr_bat, wr_data} <= {c, !c, d};
    @(posedge ref_clk) {wr_cfg, wr_bat} <= 2'b00;
    // register images trail the field state by one edge
    @(posedge ref_clk);
    @(negedge ref_clk);
  endtask
  task automatic send(input logic [7:0] b, input logic f);
    @(posedge ref_clk) {go, data, first} <= {1'b1, b, f};
    @(posedge ref_clk) go <= 0;
    // one-cycle strobes from the byte stand until the next edge
    @(posedge ref_clk);
    @(negedge ref_clk);
  endtask
  task automatic rd(input logic [7:0] c, input logic [7:0] exp);
    @(posedge ref_clk) read_req <= '{1'b1, 24'h000013, c};
    @(posedge ref_clk) read_req.valid <= 0;
    @(negedge ref_clk) chk(read_fwd.addr[7:0], exp);
  endtask
  task automatic stop_test();
    $display("checks %0d mismatches %0d", n_checks, fail_count);
    if (fail_count == 0 && n_checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (3) @(posedge ref_clk);
    reset <= 0;
    @(negedge ref_clk) chk(cfg, CFG_RESET);
    chk(bat, BAT_RESET);
    wr(1, 8'hff); chk(cfg, CFG_WMASK);
    wr(0, 8'hff); chk(bat, BAT_WMASK);
    for (i = 0; i < 8; i++) begin
      wr(1, 8'(i << DUMMY_LSB));
      chk(dck, i < 5 ? 2 * i + 2 : 0);
      chk(dxk, i < 5 ? 2 * i : 14);
    end
    $display("test registers done");
    @(posedge ref_clk) erase_suspended <= 1;
    wr(1, 8'h00); chk(cfg, 8'h08);
    @(posedge ref_clk) {erase_suspended, prog_suspended} <= 2'b01;
    wr(1, 8'hf7); chk(cfg, 8'h77);
    @(posedge ref_clk) prog_suspended <= 0;
    wr(1, 8'h00); send(CMD_ABORT, 1); chk(acc, 0);
    wr(1, 8'h02); send(CMD_ABORT, 1); chk(acc, 1);
    chk(cfg, 8'h02);
    $display("test flags done");
    for (i = 0; i < 2; i++) begin
      @(posedge ref_clk) battery_below <= !i[0];
      wr(0, 8'h1c | 8'(i));
      send(CMD_BATST, 1); chk(bsv, 1);
      chk(bsb, 8'h1c | 8'(i));
      @(negedge ref_clk) chk(bat, 8'h5c | 8'(i));
      chk({lon, tdr, ldr}, 8'h2e);
      n = 0;
      while (bat[7:6] === BAT_BUSY && n < 100) begin
        @(negedge ref_clk);
        n++;
      end
      if (n == 100) begin
        fail_count++;
        $display("unexpected at %0t: battery test never finished", $time);
        stop_test();
      end
      chk(8'(n >= (i ? LC : SC) && n <= (i ? LC : SC) + 3), 1);
      chk(bat[7:6], i ? BAT_ABOVE : BAT_BELOW);
      if (i == 0) send(CMD_ABORT, 1);
      else begin
        @(posedge ref_clk) battery_clear <= 1;
        @(posedge ref_clk) battery_clear <= 0;
      end
      repeat (2) @(negedge ref_clk);
      chk(bat[7:6], BAT_IDLE);
    end
    $display("test battery done");
    send(CMD_LOCK, 1); send(LOCK_KEY1, 0); send(8'h00, 0);
    @(negedge ref_clk);
    chk(cfg[7], 0);
    send(CMD_LOCK, 1); send(LOCK_KEY1, 0); send(LOCK_KEY2, 0);
    wr(1, 8'h00); chk(cfg, 8'h80);
    $display("test lock done");
    wr(1, 8'h01); rd(CMD_ALIGNQ, 8'h10);
    rd(8'h03, 8'h13);
    wr(1, 8'h00); rd(CMD_ALIGNQ, 8'h13);
    $display("test align done");
    stop_test();
  end
endmodule
